// >>> hdl/bts_block_xfer.sv
// load/store multiple and atomic exchange engine with apb control
// assumes memory answers rdata and abort in the cycle of the address
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
module bts_block_xfer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_trans,
  output logic [31:0] mem_addr,
  output logic mem_write,
  output logic mem_byte,
  output logic mem_seq,
  output logic mem_lock,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_abort,
  output logic irq_hold,
  output logic abort_trap,
  output logic xfer_busy
);
  import bts_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_XFER, ST_INT, ST_FILL1, ST_FILL2,
    ST_SWRD, ST_SWWR, ST_SWINT
  } bts_state_e;

  bts_state_e state_r, state_nxt;
  logic [31:0] ins_r, iaddr_r, cur_sw_r, saved_sw_r;
  logic [31:0] base_val_r, wb_val_r, addr_r, sdat_r, prdata_r;
  logic [15:0] list_r;
  logic [4:0] n_r;
  logic [7:0] cyc_r, last_cyc_r;
  logic abort_r, swap_r, first_r, trap_r, bad_r;
  logic [31:0] r1_data, r2_data;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire setup_ph = psel & ~penable;
  wire acc_ph = psel & penable;
  wire sel_instr = paddr == A_INSTR;
  wire sel_iaddr = paddr == A_IADDR;
  wire sel_stat = paddr == A_STAT;
  wire sel_cur = paddr == A_CUR;
  wire sel_saved = paddr == A_SAVED;
  wire sel_regs = paddr[11:6] == A_REGS_HI;
  wire mapped = sel_instr | sel_iaddr | sel_stat | sel_cur | sel_saved |
                sel_regs;
  wire busy = state_r != ST_IDLE;
  // everything but status is frozen while an instruction runs
  wire refuse = ~mapped | (pwrite & busy & ~sel_stat);
  wire wr_ok = acc_ph & pwrite & ~refuse;
  wire start = wr_ok & sel_instr;

  wire [15:0] new_list = pwdata[15:0];
  wire new_blk = ((pwdata & BLK_MASK) == BLK_VAL) & (|new_list);
  wire new_swp = ((pwdata & SWP_MASK) == SWP_VAL) & ~new_blk;
  wire start_go = start & (new_blk | new_swp);
  wire [4:0] new_n = popcnt16(new_list);
  wire [31:0] new_ofs = {25'h0, new_n, 2'b00};
  wire new_up = pwdata[BIT_U];
  wire new_pre = pwdata[BIT_P];
  wire [31:0] new_wb = new_up ? r2_data + new_ofs : r2_data - new_ofs;
  wire [31:0] up_start = new_pre ? r2_data + WORD_STEP : r2_data;
  wire [31:0] dn_start = new_pre ? r2_data - new_ofs :
                         r2_data - new_ofs + WORD_STEP;
  wire [31:0] new_start = new_swp ? r2_data :
                          (new_up ? up_start : dn_start); // RQ16 RQ25

  wire [31:0] stat_word = (32'(last_cyc_r) << ST_CYC) |
                          (32'(bad_r) << ST_BAD) |
                          (32'(trap_r) << ST_TRAP) |
                          (32'(busy) << ST_BUSY);
  wire [31:0] rd_mux = sel_instr ? ins_r :
                       sel_iaddr ? iaddr_r :
                       sel_stat ? stat_word :
                       sel_cur ? cur_sw_r :
                       sel_saved ? saved_sw_r :
                       sel_regs ? r2_data : 32'h0000_0000;
  wire [3:0] r2_idx = start ? pwdata[BASE_LO +: 4] : paddr[5:2];

  assign pready = 1'b1;
  assign pslverr = acc_ph & refuse;
  assign prdata = prdata_r;

  // ****************************************************************
  // instruction fields and datapath
  // ****************************************************************
  wire is_ld = ins_r[BIT_L];
  wire is_wb = ins_r[BIT_W];
  wire s_bit = ins_r[BIT_S];
  wire pc_in = ins_r[PC_IDX];
  wire [3:0] base_idx = ins_r[BASE_LO +: 4];
  wire [3:0] dest_idx = ins_r[DEST_LO +: 4];
  wire [3:0] src_idx = ins_r[3:0];
  wire [3:0] cur_idx = low_idx(list_r); // RQ23
  wire last_word = (list_r & (list_r - 16'h0001)) == 16'h0000;
  wire pc_loaded = is_ld & pc_in & ~swap_r;
  // s with pc on a load means status restore, not user bank
  wire user_xfer = s_bit & ~swap_r & ~(is_ld & pc_in); // RQ2 RQ3
  wire priv = cur_sw_r[4:0] != MODE_USER;

  wire in_xfer = state_r == ST_XFER;
  wire ab_now = mem_trans & mem_abort; // RQ9
  wire ab_any = abort_r | ab_now;
  wire load_en = in_xfer & is_ld & ~ab_any; // RQ11
  wire restore = (state_r == ST_INT) & ab_any; // RQ12
  wire sw_load = (state_r == ST_SWINT) & ~abort_r; // RQ18
  wire apb_reg = wr_ok & sel_regs;
  wire sw_restore = load_en & s_bit & (cur_idx == PC_IDX);

  wire [31:0] rd_shift = mem_rdata >> {addr_r[1:0], 3'b000};
  wire [31:0] pc_store = iaddr_r + PC_STORE_OFS; // RQ24
  wire [31:0] st_word = (~swap_r & (cur_idx == PC_IDX)) ? pc_store :
                        r1_data;

  wire a_we = load_en | restore | sw_load | apb_reg;
  wire [3:0] a_idx = load_en ? cur_idx :
                     restore ? base_idx :
                     sw_load ? dest_idx : paddr[5:2];
  wire [31:0] a_data = load_en ? mem_rdata :
                       restore ? (is_wb ? wb_val_r : base_val_r) :
                       sw_load ? sdat_r : pwdata;
  wire b_we = in_xfer & first_r & is_wb; // RQ7

  assign mem_trans = in_xfer | mem_lock;
  assign mem_addr = addr_r;
  assign mem_lock = (state_r == ST_SWRD) | (state_r == ST_SWWR); // RQ19
  assign mem_write = (in_xfer & ~is_ld) | (state_r == ST_SWWR); // RQ18
  assign mem_byte = mem_lock & s_bit; // RQ20
  assign mem_seq = in_xfer & ~first_r;
  assign mem_wdata = mem_byte ? {4{r1_data[7:0]}} : st_word;
  assign irq_hold = busy & swap_r; // RQ17
  assign abort_trap = trap_r;
  assign xfer_busy = busy;

  bts_regbank u_bank (
    .pclk(pclk),
    .presetn(presetn),
    .priv(priv),
    .a_we(a_we),
    .a_idx(a_idx),
    .a_usr(load_en & user_xfer),
    .a_data(a_data),
    .b_we(b_we),
    .b_idx(base_idx),
    .b_data(wb_val_r),
    .r1_idx(swap_r ? src_idx : cur_idx),
    .r1_usr(user_xfer),
    .r1_data(r1_data),
    .r2_idx(r2_idx),
    .r2_data(r2_data)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_go) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: state_nxt = swap_r ? ST_SWRD : ST_XFER;
      ST_XFER: begin
        if (last_word) begin
          state_nxt = is_ld ? ST_INT : ST_IDLE; // RQ14 RQ15
        end
      end
      ST_INT: begin
        // an aborted load never wrote the pc, so no refill
        state_nxt = (pc_loaded & ~abort_r) ? ST_FILL1 : ST_IDLE;
      end
      ST_FILL1: state_nxt = ST_FILL2;
      ST_SWRD: state_nxt = ST_SWWR;
      ST_SWWR: state_nxt = ST_SWINT;
      default: state_nxt = ST_IDLE;
    endcase
  end

  wire fin = busy & (state_nxt == ST_IDLE);
  wire trap_clr = wr_ok & sel_stat & pwdata[ST_TRAP];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cyc_r <= 8'h00;
      last_cyc_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cyc_r <= busy ? cyc_r + 8'h01 : 8'h00;
      if (fin) begin
        last_cyc_r <= cyc_r + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ins_r <= 32'h0000_0000;
      n_r <= 5'h00;
      swap_r <= 1'b0;
      base_val_r <= 32'h0000_0000;
      wb_val_r <= 32'h0000_0000;
    end else if (start) begin
      ins_r <= pwdata;
      n_r <= new_n;
      swap_r <= new_swp;
      base_val_r <= r2_data;
      wb_val_r <= new_wb;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= 32'h0000_0000;
      list_r <= 16'h0000;
      first_r <= 1'b0;
    end else if (start) begin
      addr_r <= new_start;
      list_r <= new_list;
      first_r <= 1'b1;
    end else if (in_xfer) begin
      addr_r <= addr_r + WORD_STEP; // RQ25
      list_r <= list_r & (list_r - 16'h0001);
      first_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdat_r <= 32'h0000_0000;
      abort_r <= 1'b0;
    end else begin
      if (state_r == ST_SWRD) begin
        sdat_r <= mem_byte ? {24'h0, rd_shift[7:0]} : mem_rdata;
      end
      // store faults only get recorded; memory side blocks the write
      abort_r <= start ? 1'b0 : ab_any; // RQ10 RQ22
    end
  end

  // set beats a simultaneous software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      trap_r <= (fin & ab_any) | (trap_r & ~trap_clr); // RQ13 RQ10
      bad_r <= (start & ~start_go) |
               (bad_r & ~(wr_ok & sel_stat & pwdata[ST_BAD]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_sw_r <= 32'h0000_0000;
      saved_sw_r <= 32'h0000_0000;
      iaddr_r <= 32'h0000_0000;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (sw_restore) begin
        cur_sw_r <= saved_sw_r; // RQ1
      end else if (wr_ok & sel_cur) begin
        cur_sw_r <= pwdata;
      end
      if (wr_ok & sel_saved) begin
        saved_sw_r <= pwdata;
      end
      if (wr_ok & sel_iaddr) begin
        iaddr_r <= pwdata;
      end
      if (setup_ph) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_swap_lock;
    $rose(mem_lock) |-> !mem_write ##1 (mem_lock && mem_write)
      ##1 !mem_lock;
  endproperty
  a_swap_lock: assert property (p_swap_lock) // RQ19
    else $error("exchange lock sequence broken");

  property p_wb_time;
    (state_r == ST_SETUP && !swap_r && is_wb) |=> b_we;
  endproperty
  a_wb_time: assert property (p_wb_time) // RQ7
    else $error("base write-back not in second cycle");

  property p_stm_cyc;
    (fin && !swap_r && !is_ld) |-> cyc_r + 8'h01 == 8'(n_r) + STM_OVH;
  endproperty
  a_stm_cyc: assert property (p_stm_cyc) // RQ15
    else $error("store multiple cycle count wrong");

  property p_ldm_cyc;
    (fin && !swap_r && is_ld) |-> cyc_r + 8'h01 == 8'(n_r) + LDM_OVH +
      ((pc_loaded && !abort_r) ? FILL_OVH : 8'h00);
  endproperty
  a_ldm_cyc: assert property (p_ldm_cyc) // RQ14
    else $error("load multiple cycle count wrong");

  property p_ld_stop;
    (in_xfer && is_ld && ab_any) |-> !load_en ##1
      (!in_xfer || !load_en);
  endproperty
  a_ld_stop: assert property (p_ld_stop) // RQ11
    else $error("load after abort not suppressed");

  property p_trap_after;
    (fin && ab_any) |=> trap_r && !busy;
  endproperty
  a_trap_after: assert property (p_trap_after) // RQ13
    else $error("abort trap not raised at completion");

  property p_step;
    (in_xfer && $past(in_xfer)) |-> mem_addr == $past(mem_addr) +
      WORD_STEP;
  endproperty
  a_step: assert property (p_step) // RQ25
    else $error("transfer address not stepped by four");

  property p_pc_store;
    (in_xfer && !is_ld && cur_idx == PC_IDX) |-> mem_wdata ==
      iaddr_r + PC_STORE_OFS;
  endproperty
  a_pc_store: assert property (p_pc_store) // RQ24
    else $error("stored pc value wrong");

  property p_restore;
    (state_r == ST_INT && abort_r) |-> a_we && a_idx == base_idx &&
      a_data == (is_wb ? wb_val_r : base_val_r);
  endproperty
  a_restore: assert property (p_restore) // RQ12
    else $error("base not restored after load abort");

  property p_status;
    sw_restore |=> cur_sw_r == $past(saved_sw_r);
  endproperty
  a_status: assert property (p_status) // RQ1
    else $error("status word not restored with pc load");

  property p_swap_len;
    (state_r == ST_SETUP && swap_r) |-> irq_hold [*4] ##1 !irq_hold;
  endproperty
  a_swap_len: assert property (p_swap_len) // RQ17
    else $error("exchange interrupt hold length wrong");
endmodule

// >>> hdl/bts_pkg.sv
// constants, decode masks and helpers of the block transfer / swap unit
// assumes a 32-bit instruction word and a 16-entry visible register set
// Functional notes
// RQ1 - ldm with pc and s: saved to current status
// RQ2 - stm with pc and s: user bank read
// RQ3 - s without pc: user bank both directions
// RQ4 - software: no write-back with user bank
// RQ5 - software: no banked read right after
// RQ6 - software: pc never the base register
// RQ7 - base written back end of second cycle
// RQ8 - loaded base beats written-back base
// RQ9 - fault allowed on any word, recoverable
// RQ10 - store fault: finish, trap, only base
// RQ11 - load fault suppresses that and later loads
// RQ12 - load fault restores base, write-back value
// RQ13 - load fault trap after sequence completes
// RQ14 - ldm cycles n+2, pc adds two
// RQ15 - stm cycles n+1
// RQ16 - l, p, u bits pick eight modes
// RQ17 - exchange read/write inseparable, interrupts held
// RQ18 - read base address, write source, load dest
// RQ19 - lock high across exchange read and write
// RQ20 - byte bit selects byte or word exchange
// RQ21 - software: pc not an exchange operand
// RQ22 - fault on exchange read or write traps
// RQ23 - list bit i is register i, ascending
// RQ24 - stored pc equals instruction address plus 12
// RQ25 - address steps four per word from start
package bts_pkg;
  localparam logic [11:0] A_INSTR = 12'h000;
  localparam logic [11:0] A_IADDR = 12'h004;
  localparam logic [11:0] A_STAT = 12'h008;
  localparam logic [11:0] A_CUR = 12'h00C;
  localparam logic [11:0] A_SAVED = 12'h010;
  localparam logic [5:0] A_REGS_HI = 6'h01;
  localparam int BIT_L = 20;
  localparam int BIT_W = 21;
  localparam int BIT_S = 22;
  localparam int BIT_U = 23;
  localparam int BIT_P = 24;
  localparam int BASE_LO = 16;
  localparam int DEST_LO = 12;
  localparam int ST_BUSY = 0;
  localparam int ST_TRAP = 1;
  localparam int ST_BAD = 2;
  localparam int ST_CYC = 8;
  localparam logic [31:0] BLK_MASK = 32'h0E00_0000;
  localparam logic [31:0] BLK_VAL = 32'h0800_0000;
  localparam logic [31:0] SWP_MASK = 32'h0FB0_0FF0;
  localparam logic [31:0] SWP_VAL = 32'h0100_0090;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] PC_STORE_OFS = 32'h0000_000C;
  localparam logic [4:0] MODE_USER = 5'h10;
  localparam logic [3:0] PC_IDX = 4'hF;
  localparam logic [3:0] BANK_LO = 4'h8;
  localparam logic [4:0] BANK_OFS = 5'h08;
  localparam int NPHYS = 23;
  localparam logic [7:0] LDM_OVH = 8'h02;
  localparam logic [7:0] FILL_OVH = 8'h02;
  localparam logic [7:0] STM_OVH = 8'h01;
  localparam logic [7:0] SWP_CYC = 8'h04;

  function automatic logic [4:0] popcnt16(input logic [15:0] v);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 16; i++) begin
      c = c + 5'(v[i]);
    end
    return c;
  endfunction

  function automatic logic [3:0] low_idx(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction
endpackage

// >>> hdl/bts_regbank.sv
// banked register file: r0-r15 plus privileged copies of r8-r14
// assumes one shared privileged bank; two write and two read ports
`timescale 1ns/1ps
module bts_regbank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic priv,
  input wire logic a_we,
  input wire logic [3:0] a_idx,
  input wire logic a_usr,
  input wire logic [31:0] a_data,
  input wire logic b_we,
  input wire logic [3:0] b_idx,
  input wire logic [31:0] b_data,
  input wire logic [3:0] r1_idx,
  input wire logic r1_usr,
  output logic [31:0] r1_data,
  input wire logic [3:0] r2_idx,
  output logic [31:0] r2_data
);
  import bts_pkg::*;

  logic [31:0] mem_r [NPHYS];

  function automatic logic [4:0] phys(input logic [3:0] idx,
                                      input logic usr);
    logic [4:0] p;
    p = {1'b0, idx};
    if (priv && !usr && idx >= BANK_LO && idx != PC_IDX) begin
      p = {1'b0, idx} + BANK_OFS;
    end
    return p;
  endfunction

  wire [4:0] pa = phys(a_idx, a_usr);
  wire [4:0] pb = phys(b_idx, 1'b0);

  assign r1_data = mem_r[phys(r1_idx, r1_usr)];
  assign r2_data = mem_r[phys(r2_idx, 1'b0)];

  // port a is written last so a load to the base beats write-back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NPHYS; i++) begin
        mem_r[i] <= 32'h0000_0000;
      end
    end else begin
      if (b_we) begin
        mem_r[pb] <= b_data;
      end
      if (a_we) begin
        mem_r[pa] <= a_data; // RQ8
      end
    end
  end
endmodule

// >>> tb/bts_mem_model.sv
// memory and memory manager beside the block: zero-wait words
// assumes rdata and abort are taken in the cycle of the address
`timescale 1ns/1ps
module bts_mem_model (
  input wire logic pclk,
  input wire logic mem_trans,
  input wire logic [31:0] mem_addr,
  input wire logic mem_write,
  input wire logic mem_byte,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_abort,
  input wire logic [31:0] bad_addr,
  input wire logic bad_en
);
  logic [31:0] mem [0:255];
  logic [31:0] last_r = 32'h0;
  wire hit = mem_trans && bad_en && mem_addr == bad_addr;
  assign mem_abort = hit;
  // idle bus shows the inverse of the last word, never stale data
  assign mem_rdata = (mem_trans && !mem_write) ? mem[mem_addr[9:2]] : ~last_r;
  always @(posedge pclk) begin
    if (mem_trans && !mem_write) begin
      last_r <= mem[mem_addr[9:2]];
    end
    if (mem_trans && mem_write && !hit) begin
      if (mem_byte) begin
        mem[mem_addr[9:2]][7:0] <= mem_wdata[7:0];
      end else begin
        mem[mem_addr[9:2]] <= mem_wdata;
      end
    end
  end
endmodule

// >>> tb/bts_block_xfer_tb_top.sv
// self-checking bench of the block transfer and exchange engine
// assumes bts_mem_model as far side; control over apb
`timescale 1ns/1ps
module bts_block_xfer_tb_top;
  import bts_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bad_en = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, bad_addr = 32'h0, prdata, mem_addr;
  logic [31:0] mem_wdata, mem_rdata, lf = 32'h14E5, st, v, x, b, a;
  logic pready, pslverr, mem_trans, mem_write, mem_byte, mem_seq;
  logic mem_lock, mem_abort, irq_hold, abort_trap, xfer_busy, e;
  logic [31:0] q[$];
  int mismatches = 0, checked = 0, lk = 0, ih = 0, k, nn = 0, bc = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    if (mem_lock === 1'b1) lk++;
    if (irq_hold === 1'b1) ih++;
    // first word of a block goes out non-sequential
    if (mem_trans === 1'b1 && mem_seq === 1'b0 && mem_lock !== 1'b1) nn++;
    if (xfer_busy === 1'b1) bc++;
  end
  bts_block_xfer u_bts_block_xfer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_trans(mem_trans), .mem_addr(mem_addr), .mem_write(mem_write),
    .mem_byte(mem_byte), .mem_seq(mem_seq), .mem_lock(mem_lock),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_abort(mem_abort),
    .irq_hold(irq_hold), .abort_trap(abort_trap), .xfer_busy(xfer_busy));
  bts_mem_model u_mem (.pclk(pclk), .mem_trans(mem_trans),
    .mem_addr(mem_addr), .mem_write(mem_write), .mem_byte(mem_byte),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_abort(mem_abort),
    .bad_addr(bad_addr), .bad_en(bad_en));
  // ****************
  // bus and model tasks
  // ****************
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rn(output logic [31:0] r);
    lf = nx(lf);
    r = lf;
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] w);
    checked++;
    if (g !== w) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, g, w);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad,
    input logic [31:0] d, output logic [31:0] r, output logic er);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      tally_and_finish();
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, ad, d, r, er);
  endtask
  task automatic rd(input logic [11:0] ad, output logic [31:0] r);
    logic er;
    apb(1'b0, ad, 32'h0, r, er);
  endtask
  task automatic sr(input int i, input logic [31:0] d);
    wr(12'h040 + 12'(4 * i), d);
  endtask
  task automatic gr(input int i, output logic [31:0] r);
    rd(12'h040 + 12'(4 * i), r);
  endtask
  task automatic fill(input logic [31:0] ad, input int n);
    logic [31:0] r;
    q.delete();
    for (int i = 0; i < n; i++) begin
      rn(r);
      q.push_back(r);
      u_mem.mem[ad[9:2] + 8'(i)] = r;
    end
  endtask
  // status sticks until cleared; poll is bounded
  task automatic run(input logic [31:0] ins, output logic [31:0] s);
    int n;
    wr(A_STAT, 32'h0000_0006);
    wr(A_IADDR, 32'h0000_0200);
    wr(A_INSTR, ins);
    n = 0;
    do begin
      rd(A_STAT, s);
      n++;
    end while (s[ST_BUSY] !== 1'b0 && n < 100);
    if (n >= 100) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 4; k++) begin
      rn(v);
      sr(0, v);
      sr(5, 32'h100);
      nn = 0;
      bc = 0;
      run(32'h0825_0021 | 32'(k) << 23, st);
      a = k[0] ? (k[1] ? 32'h104 : 32'h100) : (k[1] ? 32'hF8 : 32'hFC);
      b = k[0] ? 32'h108 : 32'hF8;
      chk(u_mem.mem[a[9:2]], v);
      chk(u_mem.mem[a[9:2] + 8'h1], b);
      gr(5, x);
      chk(x, b);
      chk(32'(st[15:8]), 32'h3);
      chk(32'(nn), 32'h1);
      chk(32'(bc), 32'h3);
      sr(5, 32'h100);
      a = k[0] ? (k[1] ? 32'h104 : 32'h100) : (k[1] ? 32'hF4 : 32'hF8);
      fill(a, 3);
      run(32'h0835_8022 | 32'(k) << 23, st);
      gr(1, x);
      chk(x, q[0]);
      gr(5, x);
      chk(x, q[1]);
      gr(15, x);
      chk(x, q[2]);
      chk(32'(st[15:8]), 32'h7);
    end
    sr(1, 32'h0);
    sr(7, 32'h77);
    sr(5, 32'h100);
    fill(32'h100, 3);
    bad_addr <= 32'h104;
    bad_en <= 1'b1;
    run(32'h08B5_00A2, st);
    gr(1, x);
    chk(x, q[0]);
    gr(7, x);
    chk(x, 32'h77);
    gr(5, x);
    chk(x, 32'h10C);
    chk(32'(st[ST_TRAP]), 32'h1);
    chk(32'(st[15:8]), 32'h5);
    chk(32'(abort_trap), 32'h1);
    sr(6, 32'h100);
    u_mem.mem[8'h40] = 32'h55;
    bad_addr <= 32'h100;
    run(32'h08A6_8001, st);
    chk(u_mem.mem[8'h40], 32'h55);
    chk(u_mem.mem[8'h41], 32'h20C);
    gr(6, x);
    chk(x, 32'h108);
    chk(32'(st[ST_TRAP]), 32'h1);
    bad_en <= 1'b0;
    rn(v);
    wr(A_CUR, 32'h10);
    sr(8, v);
    wr(A_CUR, 32'h13);
    rn(x);
    sr(8, x);
    // base was left at its restored value by the aborted load
    sr(5, 32'h100);
    run(32'h08C5_8100, st);
    chk(u_mem.mem[8'h40], v);
    fill(32'h100, 1);
    run(32'h08D5_0100, st);
    gr(8, b);
    chk(b, x);
    wr(A_CUR, 32'h10);
    gr(8, b);
    chk(b, q[0]);
    wr(A_CUR, 32'h13);
    wr(A_SAVED, 32'hF000_001F);
    run(32'h08D5_8000, st);
    rd(A_CUR, b);
    chk(b, 32'hF000_001F);
    for (k = 0; k < 3; k++) begin
      rn(v);
      rn(x);
      sr(3, v);
      sr(2, 32'h0);
      sr(4, 32'h180);
      u_mem.mem[8'h60] = x;
      bad_addr <= 32'h180;
      bad_en <= (k == 2);
      lk = 0;
      ih = 0;
      run(32'h0104_2093 | 32'(k == 1) << 22, st);
      gr(2, b);
      a = (k == 1) ? {24'h0, x[7:0]} : ((k == 2) ? 32'h0 : x);
      chk(b, a);
      a = (k == 1) ? {x[31:8], v[7:0]} : ((k == 2) ? x : v);
      chk(u_mem.mem[8'h60], a);
      chk(32'(lk), 32'h2);
      chk(32'(ih), 32'h4);
      chk(32'(st[15:8]), 32'h4);
      chk(32'(st[ST_TRAP]), 32'(k == 2));
    end
    apb(1'b0, 12'h020, 32'h0, b, e);
    chk(32'(e), 32'h1);
    tally_and_finish();
  end
endmodule
